//--- include/mtxs_map.svh
// Register offsets, field positions, reset values and timing counts for the MAC status block.
// Assumes a 40 MHz clock and word offsets within the selected register bank.
`ifndef MTXS_MAP_SVH
`define MTXS_MAP_SVH
`define MTXS_OFF_TX_STATUS   4'h2
`define MTXS_OFF_RX_CONTROL  4'h4
`define MTXS_OFF_COUNTERS    4'h6
`define MTXS_OFF_BUF_INFO    4'h8
// Transmit status bit positions
`define MTXS_B_UNDERRUN      15
`define MTXS_B_LINK          14
`define MTXS_B_ROLLOVER      12
`define MTXS_B_EXCESSIVE_DEFERRAL_FLAG       11
`define MTXS_B_CARR_LOST     10
`define MTXS_B_LATE_COL      9
`define MTXS_B_WAKE          8
`define MTXS_B_DEFERRED      7
`define MTXS_B_BCAST         6
`define MTXS_B_HEARTBEAT     5
`define MTXS_B_SIXTEEN       4
`define MTXS_B_GROUP         3
`define MTXS_B_SEVERAL       2
`define MTXS_B_ONE_COL       1
`define MTXS_B_SUCCESS       0
// Receive control bit positions
`define MTXS_B_SOFT_RST      15
`define MTXS_B_CAR_FILT      14
`define MTXS_B_FCS_REMOVE    9
`define MTXS_B_RX_ON         8
`define MTXS_B_ALL_GROUP     2
`define MTXS_B_PROMISC       1
`define MTXS_B_RX_ABORT      0
`define MTXS_RX_CONTROL_RST  16'h0000
// Memory report, 256-byte units
`define MTXS_MEM_TOTAL       8'h18
// Timing
`define MTXS_CLK_MHZ         40
`define MTXS_BIT_NS          100
`define MTXS_BYTE_NS         800
`define MTXS_DEFER_GAP_NS    6400
`define MTXS_HB_WAIT_NS      800
`define MTXS_HB_WIN_NS       1600
`define MTXS_DEFER_GAP_CYC   ((`MTXS_DEFER_GAP_NS * `MTXS_CLK_MHZ) / 1000)
`define MTXS_HB_WAIT_CYC     ((`MTXS_HB_WAIT_NS * `MTXS_CLK_MHZ + 999) / 1000)
`define MTXS_HB_WIN_CYC      ((`MTXS_HB_WIN_NS * `MTXS_CLK_MHZ) / 1000)
`define MTXS_CARR_FILT_CYC   ((12 * `MTXS_BIT_NS * `MTXS_CLK_MHZ + 999) / 1000)
`define MTXS_LATE_COL_CYC    ((64 * `MTXS_BYTE_NS * `MTXS_CLK_MHZ + 999) / 1000)
`define MTXS_EXCESSIVE_DEFERRAL_FLAG_CYC     ((1518 * 2 * `MTXS_BYTE_NS * `MTXS_CLK_MHZ) / 1000)
`define MTXS_MAX_RX_BYTES    1532
`define MTXS_MAX_COLL        16
`endif

//--- include/mtxs_pkg.sv
// Types shared by the MAC transmit status and receive control block.
// Assumes nothing of its surroundings.
package mtxs_pkg;
  // Events reported by the transmit engine, one cycle each
  typedef struct packed {
    logic start;      // Frame begins (after deferral)
    logic preamble_end;
    logic collision;
    logic underrun;
    logic done;       // Frame finished on the wire
    logic broadcast;
    logic group;
  } mtxs_tx_ev_s;
  // Receive side events
  typedef struct packed {
    logic frame_end;
    logic byte_rx;
    logic wake_match;
  } mtxs_rx_ev_s;
  typedef enum logic [2:0] {
    HB_IDLE,
    HB_WAIT_QUIET,
    HB_DELAY,
    HB_WINDOW
  } mtxs_hb_e;
endpackage : mtxs_pkg

//--- design/mtxs_core.sv
// MAC bank-0 transmit status, receive control, event counters and memory report.
// Assumes a 16-bit word register port already decoded for bank 0 and synchronous inputs.
`timescale 1ns/100ps
`include "mtxs_map.svh"

module mtxs_core
  import mtxs_pkg::*;
#(
  parameter int CNT_W      = 4,
  parameter int EXCESSIVE_DEFERRAL_FLAG_CY = `MTXS_EXCESSIVE_DEFERRAL_FLAG_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Controls from the transmit control register
  input  wire logic        tx_on_set,
  input  wire logic        tx_on_clr,
  input  wire logic        carrier_monitor_on,
  input  wire logic        halt_on_heartbeat_error,
  input  wire logic        full_duplex_on,
  input  wire logic        link_event_irq_on,
  // Transmit engine and wire
  input  wire mtxs_tx_ev_s tx_ev,
  input  wire logic        carrier_sense,
  input  wire logic        heartbeat_seen,
  input  wire logic        link_ok_in,
  // Receive path
  input  wire mtxs_rx_ev_s rx_ev,
  input  wire logic        rx_dest_group,
  input  wire logic        rx_dest_bcast,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_table_match,
  input  wire logic        rx_own_source,
  // Buffer manager
  input  wire logic        buffer_manager_reset_cmd,
  input  wire logic        mem_alloc,
  input  wire logic        mem_release,
  input  wire logic [7:0]  mem_pages,
  // Results
  output logic             transmitter_on,
  output logic             tx_jam,
  output logic             status_wr,
  output logic [15:0]      status_wdata,
  output logic             tx_status_interrupt,
  output logic             link_event_irq,
  output logic             counter_irq,
  output logic             rx_frame_active,
  output logic             rx_accept,
  output logic             rx_drop,
  output logic             fcs_remove_on,
  output logic             soft_reset_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register and soft reset
  logic [15:0] rx_control;
  logic        srst;
  logic        receiver_on, carrier_filter_on, accept_all_group, accept_everything, rx_abort_flag;
  logic        rx_busy;
  logic        rd_counters;
  logic        wr_rxc;

  assign wr_rxc      = reg_sel && reg_wr && reg_addr == `MTXS_OFF_RX_CONTROL;
  assign rd_counters = reg_sel && reg_rd && reg_addr == `MTXS_OFF_COUNTERS;
  assign srst        = rx_control[`MTXS_B_SOFT_RST];
  assign receiver_on       = rx_control[`MTXS_B_RX_ON];
  assign carrier_filter_on = rx_control[`MTXS_B_CAR_FILT];
  assign accept_all_group  = rx_control[`MTXS_B_ALL_GROUP];
  assign accept_everything = rx_control[`MTXS_B_PROMISC];

  // Soft reset bit itself survives so software can release it; config lives outside
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_control <= `MTXS_RX_CONTROL_RST;
    end else if (wr_rxc) begin
      rx_control <= reg_wdata & 16'hc307;
    end else if (srst) begin
      rx_control <= 16'h8000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit enable and per-frame timers
  logic        hb_err_stop;
  logic        late_now, lost_now, sixteen_now;
  logic [4:0]  coll_cnt;
  logic [12:0] frame_cyc;
  logic        in_frame;
  logic [16:0] defer_cyc;
  logic [8:0]  gap_cyc;

  assign late_now    = in_frame && tx_ev.collision && frame_cyc >= 13'(`MTXS_LATE_COL_CYC);
  assign lost_now    = tx_ev.preamble_end && carrier_monitor_on && !carrier_sense;
  assign sixteen_now = tx_ev.collision && coll_cnt == 5'(`MTXS_MAX_COLL - 1);

  // Error stops win over software set in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      transmitter_on <= 1'b0;
    end else if (tx_ev.underrun || lost_now || late_now || sixteen_now || hb_err_stop) begin
      transmitter_on <= 1'b0;
    end else if (tx_on_set) begin
      transmitter_on <= 1'b1;
    end else if (tx_on_clr) begin
      transmitter_on <= 1'b0;
    end
  end

  // Frame age and collision count for one frame
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      in_frame  <= 1'b0;
      frame_cyc <= '0;
      coll_cnt  <= '0;
      tx_jam    <= 1'b0;
    end else begin
      tx_jam <= late_now;
      if (tx_ev.start) begin
        in_frame  <= 1'b1;
        frame_cyc <= '0;
      end else if (tx_ev.done) begin
        in_frame <= 1'b0;
        coll_cnt <= '0;
      end else if (in_frame && frame_cyc != 13'h1fff) begin
        frame_cyc <= frame_cyc + 13'h1;
      end
      if (tx_ev.collision && coll_cnt != 5'h1f) begin
        coll_cnt <= coll_cnt + 5'h1;
      end
    end
  end

  // Deferral length and early-gap timers, both only outside a frame
  always_ff @(posedge clk) begin
    if (!rst_n || srst || in_frame) begin
      defer_cyc <= '0;
      gap_cyc   <= '0;
    end else begin
      if (carrier_sense && defer_cyc != 17'h1ffff) begin
        defer_cyc <= defer_cyc + 17'h1;
      end
      if (!carrier_sense && gap_cyc != 9'h1ff) begin
        gap_cyc <= gap_cyc + 9'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat test after each half-duplex transmission
  mtxs_hb_e   hb_state;
  logic [6:0] hb_cnt;
  logic       hb_fail;

  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      hb_state <= HB_IDLE;
      hb_cnt   <= '0;
      hb_fail  <= 1'b0;
    end else begin
      hb_fail <= 1'b0;
      case (hb_state)
        HB_IDLE: begin
          if (tx_ev.done && !full_duplex_on) begin
            hb_state <= HB_WAIT_QUIET;
          end
        end
        HB_WAIT_QUIET: begin
          hb_cnt <= '0;
          if (!carrier_sense) begin
            hb_state <= HB_DELAY;
          end
        end
        HB_DELAY: begin
          hb_cnt <= hb_cnt + 7'h1;
          if (hb_cnt == 7'(`MTXS_HB_WAIT_CYC - 1)) begin
            hb_cnt   <= '0;
            hb_state <= HB_WINDOW;
          end
        end
        HB_WINDOW: begin
          hb_cnt <= hb_cnt + 7'h1;
          if (heartbeat_seen) begin
            hb_state <= HB_IDLE;
          end else if (hb_cnt == 7'(`MTXS_HB_WIN_CYC - 1)) begin
            hb_fail  <= 1'b1;
            hb_state <= HB_IDLE;
          end
        end
        default: hb_state <= HB_IDLE;
      endcase
    end
  end
  assign hb_err_stop = hb_fail && halt_on_heartbeat_error;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit status flags
  logic [15:0] st;
  logic        link_q;
  logic        fatal;
  logic [15:0] snap;
  logic [CNT_W-1:0] cnt_one, cnt_sev, cnt_def, cnt_exc;
  logic        any_max;

  assign fatal = sixteen_now || tx_ev.underrun || lost_now || late_now ||
                 st[`MTXS_B_SIXTEEN] || st[`MTXS_B_UNDERRUN] || st[`MTXS_B_CARR_LOST] ||
                 st[`MTXS_B_LATE_COL];

  // Sticky events; sets are applied after clears so an event is never lost
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      st <= '0;
    end else begin
      if (tx_on_set) begin
        st[`MTXS_B_UNDERRUN]  <= 1'b0;
        st[`MTXS_B_CARR_LOST] <= 1'b0;
        st[`MTXS_B_LATE_COL]  <= 1'b0;
        st[`MTXS_B_HEARTBEAT] <= 1'b0;
        st[`MTXS_B_SIXTEEN]   <= 1'b0;
        st[`MTXS_B_SUCCESS]   <= 1'b0;
      end
      if (tx_ev.start) begin
        st[`MTXS_B_BCAST]   <= tx_ev.broadcast;
        st[`MTXS_B_GROUP]   <= tx_ev.group;
        st[`MTXS_B_SUCCESS] <= 1'b0;
      end
      if (rd_counters) begin
        st[`MTXS_B_ROLLOVER] <= 1'b0;
      end
      if (tx_ev.done) begin
        st[`MTXS_B_EXCESSIVE_DEFERRAL_FLAG]  <= 1'b0;
        st[`MTXS_B_DEFERRED] <= 1'b0;
        if (!fatal) begin
          st[`MTXS_B_SUCCESS] <= 1'b1;
        end
      end
      if (tx_ev.underrun) st[`MTXS_B_UNDERRUN] <= 1'b1;
      if (lost_now) st[`MTXS_B_CARR_LOST] <= 1'b1;
      if (late_now) st[`MTXS_B_LATE_COL] <= 1'b1;
      if (sixteen_now) st[`MTXS_B_SIXTEEN] <= 1'b1;
      if (hb_fail) st[`MTXS_B_HEARTBEAT] <= 1'b1;
      if (rx_ev.wake_match) st[`MTXS_B_WAKE] <= 1'b1;
      // Set on reaching 15 only, so the read that clears the counters also clears it
      if (any_max && !counter_irq) st[`MTXS_B_ROLLOVER] <= 1'b1;
      if (!in_frame && carrier_sense && gap_cyc != 9'h0 && gap_cyc < 9'(`MTXS_DEFER_GAP_CYC)) begin
        st[`MTXS_B_DEFERRED] <= 1'b1;
      end
      if (defer_cyc > 17'(EXCESSIVE_DEFERRAL_FLAG_CY)) st[`MTXS_B_EXCESSIVE_DEFERRAL_FLAG] <= 1'b1;
      if (tx_ev.collision) begin
        if (coll_cnt == 5'h0) st[`MTXS_B_ONE_COL] <= 1'b1;
        else st[`MTXS_B_SEVERAL] <= 1'b1;
      end
      // Collision flags drop one cycle after a success is reported
      if (st[`MTXS_B_SUCCESS] && !tx_ev.collision) begin
        st[`MTXS_B_ONE_COL] <= 1'b0;
        st[`MTXS_B_SEVERAL] <= 1'b0;
      end
      st[13] <= 1'b0;
      st[`MTXS_B_LINK] <= 1'b0;
    end
  end

  // Live view; link state is real time and bit 13 reads zero
  assign snap = {st[15], link_ok_in, 1'b0, st[12:0]};

  // Completion copy into the first word of the packet area
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      status_wr    <= 1'b0;
      status_wdata <= '0;
    end else begin
      status_wr <= tx_ev.done;
      if (tx_ev.done) begin
        status_wdata <= snap | {15'h0, !fatal}; // live bit lands a cycle late
      end
    end
  end

  // Link change and heartbeat stop interrupts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_q              <= 1'b0;
      link_event_irq      <= 1'b0;
      tx_status_interrupt <= 1'b0;
    end else begin
      link_q              <= link_ok_in;
      link_event_irq      <= (link_q != link_ok_in) && link_event_irq_on;
      tx_status_interrupt <= hb_err_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saturating event counters, one step per packet at completion
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic ev);
    sat_inc = (ev && v != {CNT_W{1'b1}}) ? v + 1'b1 : v;
  endfunction : sat_inc

  logic was_def, was_exc;
  assign any_max = (&cnt_one) | (&cnt_sev) | (&cnt_def) | (&cnt_exc);

  always_ff @(posedge clk) begin
    if (!rst_n || srst || rd_counters) begin
      cnt_one <= '0;
      cnt_sev <= '0;
      cnt_def <= '0;
      cnt_exc <= '0;
      counter_irq <= 1'b0;
    end else begin
      counter_irq <= any_max;
      if (tx_ev.done) begin
        cnt_one <= sat_inc(cnt_one, coll_cnt == 5'h1);
        cnt_sev <= sat_inc(cnt_sev, coll_cnt >= 5'h2);
        cnt_def <= sat_inc(cnt_def, was_def || st[`MTXS_B_DEFERRED]);
        cnt_exc <= sat_inc(cnt_exc, was_exc || st[`MTXS_B_EXCESSIVE_DEFERRAL_FLAG]);
      end
    end
  end

  // Deferral seen at any retry counts once per packet
  always_ff @(posedge clk) begin
    if (!rst_n || srst || tx_ev.done) begin
      was_def <= 1'b0;
      was_exc <= 1'b0;
    end else begin
      was_def <= was_def | st[`MTXS_B_DEFERRED];
      was_exc <= was_exc | st[`MTXS_B_EXCESSIVE_DEFERRAL_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive framing, filtering and length abort
  logic [5:0]  filt_cnt;
  logic [10:0] rx_bytes;
  logic        accept_now;
  logic        abort_set;

  // Promiscuous mode hears own frames back only in full duplex
  assign accept_now = (accept_everything && (full_duplex_on || !rx_own_source)) ||
                      (rx_dest_group && (accept_all_group || rx_table_match || rx_dest_bcast)) ||
                      (!rx_dest_group && rx_addr_match);
  assign abort_set  = rx_busy && rx_ev.byte_rx && rx_bytes == 11'(`MTXS_MAX_RX_BYTES);

  // Frame starts only when enabled; a disable mid-frame lets it finish
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      rx_busy  <= 1'b0;
      filt_cnt <= '0;
      rx_bytes <= '0;
    end else begin
      if (!carrier_sense) filt_cnt <= '0;
      else if (filt_cnt != 6'h3f) filt_cnt <= filt_cnt + 6'h1;
      if (!rx_busy && receiver_on && carrier_sense &&
          (!carrier_filter_on || filt_cnt >= 6'(`MTXS_CARR_FILT_CYC))) begin
        rx_busy  <= 1'b1;
        rx_bytes <= '0;
      end else if (rx_busy && rx_ev.frame_end) begin
        rx_busy <= 1'b0;
      end else if (rx_busy && rx_ev.byte_rx && rx_bytes != 11'h7ff) begin
        rx_bytes <= rx_bytes + 11'h1;
      end
    end
  end

  // Sticky abort lives in the control register image
  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      rx_abort_flag <= 1'b0;
    end else if (abort_set) begin
      rx_abort_flag <= 1'b1;
    end else if (wr_rxc && !reg_wdata[`MTXS_B_RX_ABORT]) begin
      rx_abort_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || srst) begin
      rx_frame_active   <= 1'b0;
      rx_accept         <= 1'b0;
      rx_drop           <= 1'b0;
      fcs_remove_on     <= 1'b0;
      soft_reset_active <= rst_n && srst; // Must show while soft reset holds
    end else begin
      rx_frame_active   <= rx_busy;
      rx_accept         <= rx_busy && rx_ev.frame_end && accept_now &&
                           rx_bytes <= 11'(`MTXS_MAX_RX_BYTES);
      rx_drop           <= abort_set;
      fcs_remove_on     <= rx_control[`MTXS_B_FCS_REMOVE];
      soft_reset_active <= srst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free memory, restored by reset or buffer manager reset
  logic [7:0] mem_free;
  always_ff @(posedge clk) begin
    if (!rst_n || srst || buffer_manager_reset_cmd) begin
      mem_free <= `MTXS_MEM_TOTAL;
    end else if (mem_alloc && mem_free >= mem_pages) begin
      mem_free <= mem_free - mem_pages;
    end else if (mem_release && (9'(mem_free) + 9'(mem_pages)) <= 9'(`MTXS_MEM_TOTAL)) begin
      mem_free <= mem_free + mem_pages;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unknown offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_sel && reg_rd) begin
      case (reg_addr)
        `MTXS_OFF_TX_STATUS:  reg_rdata <= snap;
        `MTXS_OFF_RX_CONTROL: reg_rdata <= {rx_control[15:1], rx_abort_flag};
        `MTXS_OFF_COUNTERS:   reg_rdata <= {cnt_exc, cnt_def, cnt_sev, cnt_one};
        `MTXS_OFF_BUF_INFO:   reg_rdata <= {`MTXS_MEM_TOTAL, mem_free};
        default:              reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule : mtxs_core

//--- verification/mtxs_txeng_model.sv
// Transmit engine model: plays one frame per go pulse as event pulses.
// Assumes n_col, urun, bc and gp are held by the bench for the whole frame.
`timescale 1ns/100ps
module mtxs_txeng_model
  import mtxs_pkg::*;
(
  // Clock and frame request
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] n_col,
  input  wire logic       urun,
  input  wire logic       bc,
  input  wire logic       gp,
  // Engine and transceiver
  output mtxs_tx_ev_s     tx_ev,
  output logic            heartbeat_seen
);
  logic [7:0] cnt;
  logic [7:0] c_end;
  assign c_end = 8'h04 + {2'h0, n_col, 1'b0};
  // Frame step counter, idle at zero
  always_ff @(posedge clk) begin
    if (go) cnt <= 8'h01;
    else if (cnt != 8'h00 && cnt < c_end + 8'h64) cnt <= cnt + 8'h01;
    else cnt <= 8'h00;
  end
  // Collisions two cycles apart, then underrun and done
  assign tx_ev.start        = (cnt == 8'h01);
  assign tx_ev.broadcast    = tx_ev.start & bc;
  assign tx_ev.group        = tx_ev.start & gp;
  assign tx_ev.preamble_end = (cnt == 8'h03);
  assign tx_ev.collision    = cnt >= 8'h04 && cnt < c_end && !cnt[0];
  assign tx_ev.underrun     = urun && cnt == c_end;
  assign tx_ev.done         = (cnt == c_end + 8'h01);
  // Heartbeat sits well inside the test window, so no error is seen
  assign heartbeat_seen = cnt > c_end + 8'h28 && cnt < c_end + 8'h50;
endmodule : mtxs_txeng_model

//--- verification/mtxs_checker.sv
// Port checker for the MAC status block, bound to mtxs_core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module mtxs_checker
  import mtxs_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Events and controls
  input wire mtxs_tx_ev_s tx_ev,
  input wire logic        link_ok_in,
  input wire logic        link_event_irq_on,
  // Results
  input wire logic        transmitter_on,
  input wire logic        status_wr,
  input wire logic        counter_irq,
  input wire logic        link_event_irq,
  input wire logic        fcs_remove_on,
  input wire logic        soft_reset_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd;
  logic wr4;
  // Decoded accesses
  assign rd  = reg_sel & reg_rd;
  assign wr4 = reg_sel & reg_wr & (reg_addr == 4'h4);
  ////////////////////////////////////////////////////////////////////////
  chk_underrun_stop: assert property (tx_ev.underrun |=> !transmitter_on)
    else $error("transmitter still on after underrun");
  chk_status_copy: assert property (tx_ev.done |=> status_wr)
    else $error("status copy missing after done");
  chk_rx_mask: assert property (rd && reg_addr == 4'h4 |=> (reg_rdata & 16'h3cf8) == 16'h0000)
    else $error("unused receive control bit reads one");
  chk_mem_total: assert property (rd && reg_addr == 4'h8 |=> reg_rdata[15:8] == 8'h18)
    else $error("memory size field wrong");
  // A done in the read cycle is excluded, though the clear wins and drops its count
  chk_count_clear: assert property (rd && reg_addr == 4'h6 && !tx_ev.done |=> !counter_irq)
    else $error("counter alert survives read");
  chk_fcs_follow: assert property (wr4 && !reg_wdata[15] && !soft_reset_active
    |-> ##2 fcs_remove_on == $past(reg_wdata[9], 2))
    else $error("crc removal does not follow write");
  chk_soft_level: assert property (wr4 |-> ##2 soft_reset_active == $past(reg_wdata[15], 2))
    else $error("soft reset level does not follow write");
  chk_link_irq: assert property (link_event_irq_on && $changed(link_ok_in) |-> ##[1:4] link_event_irq)
    else $error("no link event pulse");
  // Main scenarios reached
  cover property (status_wr);
  cover property (counter_irq);
  cover property (link_event_irq);
endmodule : mtxs_checker

bind mtxs_core mtxs_checker u_chk (.clk, .rst_n, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .tx_ev, .link_ok_in, .link_event_irq_on, .transmitter_on, .status_wr, .counter_irq,
  .link_event_irq, .fcs_remove_on, .soft_reset_active);

//--- verification/tb_top.sv
// Self-checking bench for mtxs_core with a transmit engine model.
// Assumes inputs driven at the falling edge and a 40 MHz clock.
`timescale 1ns/100ps
module tb_top
  import mtxs_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic tx_on_set = 1'b0, link_ok_in = 1'b0, go = 1'b0, urun = 1'b0, bc = 1'b0, gp = 1'b0;
  logic cmon = 1'b0, le_on = 1'b1, cs = 1'b0, rgrp = 1'b0, ram = 1'b0, rtm = 1'b0;
  logic mrst = 1'b0, mal = 1'b0, mrel = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [4:0]  n_col = 5'h00;
  logic [7:0]  mpg = 8'h00;
  mtxs_rx_ev_s rxe = '0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, status_wdata, sw, d;
  logic        transmitter_on, status_wr, link_event_irq, counter_irq, fcs_remove_on, soft_reset_active, hb;
  logic        rx_accept, rx_frame_active;
  mtxs_tx_ev_s tx_ev;
  int          n_errors = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  mtxs_txeng_model u_eng (.clk(clk), .go(go), .n_col(n_col), .urun(urun), .bc(bc), .gp(gp),
    .tx_ev(tx_ev), .heartbeat_seen(hb));
  // Small deferral count keeps the run short
  mtxs_core #(.EXCESSIVE_DEFERRAL_FLAG_CY(50)) dut (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_on_set(tx_on_set), .tx_on_clr(1'b0), .carrier_monitor_on(cmon), .halt_on_heartbeat_error(1'b0),
    .full_duplex_on(1'b0), .link_event_irq_on(le_on), .tx_ev(tx_ev), .carrier_sense(cs),
    .heartbeat_seen(hb), .link_ok_in(link_ok_in), .rx_ev(rxe), .rx_dest_group(rgrp), .rx_dest_bcast(1'b0),
    .rx_addr_match(ram), .rx_table_match(rtm), .rx_own_source(1'b0), .buffer_manager_reset_cmd(mrst),
    .mem_alloc(mal), .mem_release(mrel), .mem_pages(mpg), .transmitter_on(transmitter_on), .tx_jam(),
    .status_wr(status_wr), .status_wdata(status_wdata), .tx_status_interrupt(), .link_event_irq(link_event_irq),
    .counter_irq(counter_irq), .rx_frame_active(rx_frame_active), .rx_accept(rx_accept), .rx_drop(),
    .fcs_remove_on(fcs_remove_on),
    .soft_reset_active(soft_reset_active));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] wd);
    @(negedge clk);
    reg_sel = 1'b1; reg_wr = w; reg_rd = !w; reg_addr = a; reg_wdata = wd;
    @(negedge clk);
    reg_sel = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    d = reg_rdata;
  endtask : acc
  task automatic tx_on();
    @(negedge clk) tx_on_set = 1'b1;
    @(negedge clk) tx_on_set = 1'b0;
  endtask : tx_on
  // One frame; the tail covers the heartbeat delay and window
  task automatic frame(input logic [4:0] nc, input logic ur, input logic b, input logic g);
    int i;
    @(negedge clk);
    n_col = nc; urun = ur; bc = b; gp = g; go = 1'b1;
    @(negedge clk) go = 1'b0;
    for (i = 0; i < 200 && status_wr !== 1'b1; i++) @(negedge clk);
    sw = (status_wr === 1'b1) ? status_wdata : 16'hxxxx;
    repeat (120) @(negedge clk);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    acc(1'b0, 4'h4, 16'h0000); chk(d, 16'h0000);
    acc(1'b0, 4'h8, 16'h0000); chk(d, 16'h1818);
    acc(1'b0, 4'h2, 16'h0000); chk(d, 16'h0000);
    acc(1'b0, 4'h3, 16'h0000); chk(d, 16'h0000);
  endtask : t_defaults
  task automatic t_rx_control();
    acc(1'b1, 4'h4, 16'h4307); acc(1'b0, 4'h4, 16'h0000); chk(d, 16'h4306);
    chk({15'h0, fcs_remove_on}, 16'h0001);
    acc(1'b1, 4'h4, 16'h8000); @(negedge clk); chk({15'h0, soft_reset_active}, 16'h0001);
    acc(1'b1, 4'h4, 16'h0000); acc(1'b0, 4'h4, 16'h0000); chk(d, 16'h0000);
    chk({15'h0, fcs_remove_on}, 16'h0000);
  endtask : t_rx_control
  task automatic t_frames();
    tx_on();
    frame(5'h01, 1'b0, 1'b1, 1'b0); chk(sw & 16'h0049, 16'h0041);
    acc(1'b0, 4'h6, 16'h0000); chk(d, 16'h0001);
    acc(1'b0, 4'h6, 16'h0000); chk(d, 16'h0000);
    frame(5'h00, 1'b0, 1'b0, 1'b1); chk(sw & 16'h0049, 16'h0009);
  endtask : t_frames
  task automatic t_underrun();
    frame(5'h00, 1'b1, 1'b0, 1'b0); chk({15'h0, transmitter_on}, 16'h0000);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h8001, 16'h8000);
    tx_on(); acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h8001, 16'h0000);
  endtask : t_underrun
  task automatic t_sixteen();
    frame(5'h10, 1'b0, 1'b0, 1'b0); chk({15'h0, transmitter_on}, 16'h0000);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h0011, 16'h0010);
    acc(1'b0, 4'h6, 16'h0000); chk(d, 16'h0010);
    tx_on();
  endtask : t_sixteen
  task automatic t_rollover();
    repeat (15) frame(5'h01, 1'b0, 1'b0, 1'b0);
    chk({15'h0, counter_irq}, 16'h0001);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h1000, 16'h1000);
    acc(1'b0, 4'h6, 16'h0000); chk(d, 16'h000f);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h1000, 16'h0000);
  endtask : t_rollover
  task automatic t_link();
    int i;
    @(negedge clk) link_ok_in = 1'b1;
    for (i = 0; i < 8 && link_event_irq !== 1'b1; i++) @(negedge clk);
    chk({15'h0, link_event_irq}, 16'h0001);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h4000, 16'h4000);
    le_on = 1'b0; link_ok_in = 1'b0;
    @(negedge clk) chk({15'h0, link_event_irq}, 16'h0000);
  endtask : t_link
  task automatic t_lost();
    cmon = 1'b1; frame(5'h00, 1'b0, 1'b0, 1'b0); cmon = 1'b0;
    chk({15'h0, transmitter_on}, 16'h0000);
    acc(1'b0, 4'h2, 16'h0000); chk(d & 16'h0401, 16'h0400);
    tx_on();
  endtask : t_lost
  task automatic t_mem();
    @(negedge clk) mpg = 8'h05; mal = 1'b1;
    @(negedge clk) mal = 1'b0;
    acc(1'b0, 4'h8, 16'h0000); chk(d, 16'h1813);
    @(negedge clk) mrst = 1'b1;
    @(negedge clk) mrst = 1'b0;
    acc(1'b0, 4'h8, 16'h0000); chk(d, 16'h1818);
  endtask : t_mem
  // Short carrier keeps the deferral timers out of the way
  task automatic t_rx();
    acc(1'b1, 4'h4, 16'h0100);
    @(negedge clk) cs = 1'b1;
    @(negedge clk) ram = 1'b1; rxe.frame_end = 1'b1;
    @(negedge clk) chk({14'h0, rx_accept, rx_frame_active}, 16'h0003);
    cs = 1'b0; ram = 1'b0; rxe = '0;
    acc(1'b1, 4'h4, 16'h0000);
  endtask : t_rx
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_defaults(); t_rx_control(); t_frames(); t_underrun();
    t_sixteen(); t_rollover(); t_lost(); t_link(); t_mem(); t_rx();
    print_verdict();
  end
  // Watchdog: tests need about 2700 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
